//--- design/vsf_pkg.sv
// Package of constants and types for the velocity mode status flags
// Contract
// - Bit 15 high while load reaches the motor torque upper limit, else low.
// - Bit 12 one when internal command speed is zero, else zero.
// - Bit 11 high while any internal limit function is active.
// - Halt clear: bit 10 set once feedback speed reaches target velocity.
// - Halt set: bit 10 low while command speed nonzero, set at zero.
// - Halt clear: bit 10 mirrors velocity-attained output, configurable mode and range.
// - Bit 9 rises to one once initialization has completed.
// - Bit 7 zero without information condition, clears itself when cause removed.
`default_nettype none
package vsf_pkg;
  // ==========================================================
  // Widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SPD_W  = 32;
  localparam int unsigned SYNC_W = 4;

  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONTROL  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TARGET   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_VA_MODE  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_VA_RANGE = 8'h10;

  // ==========================================================
  // Field positions and reset values
  localparam int unsigned CTL_HALT_BIT = 8;
  localparam logic [15:0] CONTROL_RST  = 16'h0000;
  localparam logic [SPD_W-1:0] TARGET_RST   = 32'h0000_0000;
  localparam logic [SPD_W-1:0] VA_RANGE_RST = 32'h0000_000A;
  localparam logic [DATA_W-1:0] RD_ZERO     = 32'h0000_0000;
  localparam logic [SPD_W-1:0] SPD_ZERO     = 32'h0000_0000;

  // ==========================================================
  // Velocity attained judgment modes
  typedef enum logic [1:0] {
    VA_WINDOW = 2'b00,
    VA_ABOVE  = 2'b01
  } vsf_va_mode_t;

  // ==========================================================
  // Status word layout
  typedef struct packed {
    logic       torque_limit_reached_flag;
    logic [1:0] unused_hi;
    logic       cmd_speed_zero;
    logic       limit_active;
    logic       target_reached;
    logic       remote;
    logic       unused_b8;
    logic       warning;
    logic [6:0] unused_lo;
  } vsf_status_t;

  localparam vsf_status_t STATUS_RST = 16'h0000;
endpackage : vsf_pkg
`default_nettype wire

//--- design/vsf_va_detect.sv
// Velocity attained judgment for the target reached flag
`default_nettype none
module vsf_va_detect #(
  parameter int unsigned SPD_W = vsf_pkg::SPD_W
) (
  input  wire logic signed [SPD_W-1:0] fb_speed_i,
  input  wire logic signed [SPD_W-1:0] target_i,
  input  wire logic        [SPD_W-1:0] range_i,
  input  wire vsf_pkg::vsf_va_mode_t   mode_i,
  output logic                         attained_o
);
  // ==========================================================
  // Magnitudes and difference
  logic [SPD_W:0] diff_abs;
  logic [SPD_W:0] fb_abs;
  logic [SPD_W:0] tgt_abs;
  logic signed [SPD_W:0] diff;

  always_comb begin
    diff     = $signed({fb_speed_i[SPD_W-1], fb_speed_i})
               - $signed({target_i[SPD_W-1], target_i});
    diff_abs = diff[SPD_W] ? (SPD_W+1)'(-diff) : diff;
    fb_abs   = fb_speed_i[SPD_W-1] ? (SPD_W+1)'(-$signed({1'b1, fb_speed_i}))
                                   : {1'b0, fb_speed_i};
    tgt_abs  = target_i[SPD_W-1] ? (SPD_W+1)'(-$signed({1'b1, target_i}))
                                 : {1'b0, target_i};
    case (mode_i)
      vsf_pkg::VA_ABOVE: attained_o = (fb_abs + {1'b0, range_i}) >= tgt_abs;
      default:           attained_o = diff_abs <= {1'b0, range_i};
    endcase
  end
endmodule : vsf_va_detect
`default_nettype wire

//--- design/vsf_status_flags.sv
// Upper status flags of the drive status word in profile velocity mode
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`default_nettype none
module vsf_status_flags #(
  parameter int unsigned ADDR_W = vsf_pkg::ADDR_W,
  parameter int unsigned DATA_W = vsf_pkg::DATA_W,
  parameter int unsigned SPD_W  = vsf_pkg::SPD_W
) (
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    ce_i,
  // Register port
  input  wire logic [ADDR_W-1:0]       addr_i,
  input  wire logic [DATA_W-1:0]       wr_data_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [DATA_W-1:0]       rd_data_o,
  // Drive internals
  input  wire logic                    torque_at_limit_i,
  input  wire logic signed [SPD_W-1:0] cmd_speed_i,
  input  wire logic signed [SPD_W-1:0] fb_speed_i,
  input  wire logic                    soft_limit_i,
  input  wire logic                    mech_limit_i,
  input  wire logic                    init_done_i,
  input  wire logic                    info_cond_i,
  // Pins
  input  wire logic                    forward_travel_sensor_i,
  input  wire logic                    reverse_travel_sensor_i,
  input  wire logic                    forward_motion_inhibit_i,
  input  wire logic                    reverse_motion_inhibit_i,
  // Outputs
  output logic [15:0]                  drive_status_word_o,
  output logic                         velocity_attained_output_o,
  output logic                         halt_o
);
  // ==========================================================
  // Reset release
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ==========================================================
  // Pin synchronisers
  logic [vsf_pkg::SYNC_W-1:0] pin_raw;
  logic [vsf_pkg::SYNC_W-1:0] sync1_r;
  logic [vsf_pkg::SYNC_W-1:0] sync2_r;
  logic [vsf_pkg::SYNC_W-1:0] sync1_nxt;
  logic [vsf_pkg::SYNC_W-1:0] sync2_nxt;

  assign pin_raw = {reverse_motion_inhibit_i, forward_motion_inhibit_i,
                    reverse_travel_sensor_i, forward_travel_sensor_i};

  always_comb begin
    sync1_nxt = sync1_r;
    sync2_nxt = sync2_r;
    if (ce_i) begin
      sync1_nxt = pin_raw;
      sync2_nxt = sync1_r;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  // ==========================================================
  // Configuration registers
  logic [15:0]           control_r;
  logic [15:0]           control_nxt;
  logic [SPD_W-1:0]      target_r;
  logic [SPD_W-1:0]      target_nxt;
  vsf_pkg::vsf_va_mode_t va_mode_r;
  vsf_pkg::vsf_va_mode_t va_mode_nxt;
  logic [SPD_W-1:0]      va_range_r;
  logic [SPD_W-1:0]      va_range_nxt;
  logic [DATA_W-1:0]     rd_data_r;
  logic [DATA_W-1:0]     rd_data_nxt;
  vsf_pkg::vsf_status_t  status_r;
  vsf_pkg::vsf_status_t  status_nxt;

  always_comb begin
    control_nxt  = control_r;
    target_nxt   = target_r;
    va_mode_nxt  = va_mode_r;
    va_range_nxt = va_range_r;
    rd_data_nxt  = vsf_pkg::RD_ZERO;
    if (ce_i) begin
      if (wr_i) begin
        if (addr_i == vsf_pkg::OFS_CONTROL) begin
          control_nxt = wr_data_i[15:0];
        end else if (addr_i == vsf_pkg::OFS_TARGET) begin
          target_nxt = wr_data_i[SPD_W-1:0];
        end else if (addr_i == vsf_pkg::OFS_VA_MODE) begin
          va_mode_nxt = vsf_pkg::vsf_va_mode_t'(wr_data_i[1:0]);
        end else if (addr_i == vsf_pkg::OFS_VA_RANGE) begin
          va_range_nxt = wr_data_i[SPD_W-1:0];
        end
        // Status word offset takes no write
      end
      if (rd_i) begin
        if (addr_i == vsf_pkg::OFS_STATUS) begin
          rd_data_nxt = {16'h0000, status_r};
        end else if (addr_i == vsf_pkg::OFS_CONTROL) begin
          rd_data_nxt = {16'h0000, control_r};
        end else if (addr_i == vsf_pkg::OFS_TARGET) begin
          rd_data_nxt = target_r;
        end else if (addr_i == vsf_pkg::OFS_VA_MODE) begin
          rd_data_nxt = {30'h0000_0000, va_mode_r};
        end else if (addr_i == vsf_pkg::OFS_VA_RANGE) begin
          rd_data_nxt = va_range_r;
        end
      end
    end else begin
      rd_data_nxt = rd_data_r;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      control_r  <= vsf_pkg::CONTROL_RST;
      target_r   <= vsf_pkg::TARGET_RST;
      va_mode_r  <= vsf_pkg::VA_WINDOW;
      va_range_r <= vsf_pkg::VA_RANGE_RST;
      rd_data_r  <= vsf_pkg::RD_ZERO;
    end else begin
      control_r  <= control_nxt;
      target_r   <= target_nxt;
      va_mode_r  <= va_mode_nxt;
      va_range_r <= va_range_nxt;
      rd_data_r  <= rd_data_nxt;
    end
  end

  // ==========================================================
  // Velocity attained judgment
  logic va_now;
  logic va_r;
  logic va_nxt;

  vsf_va_detect #(
    .SPD_W (SPD_W)
  ) u_va (
    .fb_speed_i (fb_speed_i),
    .target_i   (target_r),
    .range_i    (va_range_r),
    .mode_i     (va_mode_r),
    .attained_o (va_now)
  );

  // ==========================================================
  // Status flags
  logic halt;
  logic cmd_zero;

  always_comb begin
    halt       = control_r[vsf_pkg::CTL_HALT_BIT];
    cmd_zero   = cmd_speed_i == vsf_pkg::SPD_ZERO;
    va_nxt     = va_r;
    status_nxt = status_r;
    if (ce_i) begin
      va_nxt                               = va_now;
      status_nxt                           = vsf_pkg::STATUS_RST;
      status_nxt.torque_limit_reached_flag = torque_at_limit_i;
      status_nxt.cmd_speed_zero            = cmd_zero;
      status_nxt.limit_active              = (|sync2_r) | soft_limit_i
                                             | mech_limit_i;
      if (halt) begin
        status_nxt.target_reached = cmd_zero;
      end else begin
        status_nxt.target_reached = va_now;
      end
      status_nxt.remote                    = init_done_i;
      status_nxt.warning                   = info_cond_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      status_r <= vsf_pkg::STATUS_RST;
      va_r     <= 1'b0;
    end else begin
      status_r <= status_nxt;
      va_r     <= va_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign drive_status_word_o        = status_r;
  assign velocity_attained_output_o = va_r;
  assign halt_o                     = control_r[vsf_pkg::CTL_HALT_BIT];
  assign rd_data_o                  = rd_data_r;
endmodule : vsf_status_flags
`default_nettype wire

//--- testbench/vsf_status_flags_assertions.sv
// Checker of the status flag timing
`default_nettype none
module vsf_status_flags_chk #(
  parameter int unsigned ADDR_W = vsf_pkg::ADDR_W,
  parameter int unsigned DATA_W = vsf_pkg::DATA_W,
  parameter int unsigned SPD_W  = vsf_pkg::SPD_W
) (
  input wire logic                    clk_sys_i,
  input wire logic                    rst_n_i,
  input wire logic                    ce_i,
  input wire logic [ADDR_W-1:0]       addr_i,
  input wire logic                    rd_i,
  input wire logic [DATA_W-1:0]       rd_data_o,
  input wire logic                    torque_at_limit_i,
  input wire logic signed [SPD_W-1:0] cmd_speed_i,
  input wire logic                    soft_limit_i,
  input wire logic                    mech_limit_i,
  input wire logic                    init_done_i,
  input wire logic                    info_cond_i,
  input wire logic                    forward_travel_sensor_i,
  input wire logic                    reverse_travel_sensor_i,
  input wire logic                    forward_motion_inhibit_i,
  input wire logic                    reverse_motion_inhibit_i,
  input wire logic [15:0]             drive_status_word_o,
  input wire logic                    velocity_attained_output_o,
  input wire logic                    halt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Settle counter after reset
  logic [2:0] age_r;
  logic       ok;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) age_r <= 3'h0;
    else if (age_r != 3'h7) age_r <= age_r + 3'h1;
  end
  assign ok = age_r == 3'h7;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // Properties
  sequence s_run; ok && $past(ce_i); endsequence
  sequence s_rd; ok && ce_i && rd_i && addr_i == vsf_pkg::OFS_STATUS; endsequence
  sequence s_run3; s_run ##0 ($past(ce_i, 2) && $past(ce_i, 3)); endsequence
  property p_torque; s_run |-> drive_status_word_o[15] == $past(torque_at_limit_i); endproperty
  property p_zero; s_run |-> drive_status_word_o[12] == ($past(cmd_speed_i) == 0); endproperty
  property p_limit; s_run3 |-> drive_status_word_o[11] == ($past(soft_limit_i | mech_limit_i)
    | $past(forward_travel_sensor_i | reverse_travel_sensor_i | forward_motion_inhibit_i
    | reverse_motion_inhibit_i, 3)); endproperty
  property p_halt; s_run ##0 (halt_o && $past(halt_o))
    |-> drive_status_word_o[10] == ($past(cmd_speed_i) == 0); endproperty
  property p_va; s_run ##0 (!halt_o && !$past(halt_o))
    |-> drive_status_word_o[10] == velocity_attained_output_o; endproperty
  property p_init; s_run |-> drive_status_word_o[9] == $past(init_done_i); endproperty
  property p_warn; s_run |-> drive_status_word_o[7] == $past(info_cond_i); endproperty
  property p_rsv; ok |-> drive_status_word_o[14:13] == 2'h0; endproperty
  property p_rd;
    s_rd |=> rd_data_o == {16'h0000, $past(drive_status_word_o)};
  endproperty
  property p_idle; ok && ce_i && !rd_i |=> rd_data_o == vsf_pkg::RD_ZERO; endproperty
  // ==========================================================
  // Assertions
  a_torque: assert property (p_torque) else $error("bit 15 wrong");
  a_zero: assert property (p_zero) else $error("bit 12 wrong");
  a_limit: assert property (p_limit) else $error("bit 11 wrong");
  a_halt: assert property (p_halt) else $error("bit 10 halt wrong");
  a_va: assert property (p_va) else $error("bit 10 va wrong");
  a_init: assert property (p_init) else $error("bit 9 wrong");
  a_warn: assert property (p_warn) else $error("bit 7 wrong");
  a_rsv: assert property (p_rsv) else $error("bits 14 13 set");
  a_rd: assert property (p_rd) else $error("read word wrong");
  a_idle: assert property (p_idle) else $error("read data not idle");
endmodule : vsf_status_flags_chk
bind vsf_status_flags vsf_status_flags_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .SPD_W(SPD_W))
  u_chk (.clk_sys_i, .rst_n_i, .ce_i, .addr_i, .rd_i, .rd_data_o, .torque_at_limit_i,
  .cmd_speed_i, .soft_limit_i, .mech_limit_i, .init_done_i, .info_cond_i,
  .forward_travel_sensor_i, .reverse_travel_sensor_i, .forward_motion_inhibit_i,
  .reverse_motion_inhibit_i, .drive_status_word_o, .velocity_attained_output_o, .halt_o);
`default_nettype wire

//--- testbench/vsf_bus_master.sv
// Bus master model reading and writing the register port
`default_nettype none
module vsf_bus_master (
  input  wire logic        clk_sys_i,
  input  wire logic [31:0] rd_data_i,
  output var logic  [7:0]  addr_o,
  output var logic  [31:0] wr_data_o,
  output var logic         wr_o,
  output var logic         rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_o = 8'h00;
    wr_data_o = 32'h0000_0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    wr_data_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    @(posedge clk_sys_i);
    d = rd_data_i;
  endtask : rd_reg
endmodule : vsf_bus_master
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench of the status flags
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, tq = 1'b0, sl = 1'b0, ml = 1'b0;
  logic ini = 1'b0, inf = 1'b0, va, halt;
  logic [3:0] pin = 4'h0;
  logic signed [31:0] cmd = 32'sh1, fb = 32'sh0;
  wire logic [7:0] addr;
  wire logic [31:0] wdat, rdat;
  wire logic wr, rd;
  logic [15:0] dsw;
  logic [15:0] seed = 16'h0008;
  int failures = 0, num_checks = 0, cycles = 0;
  int exp_q[$];
  always #12.5 clk_sys_i = ~clk_sys_i;
  vsf_bus_master m (.clk_sys_i(clk_sys_i), .rd_data_i(rdat), .addr_o(addr),
    .wr_data_o(wdat), .wr_o(wr), .rd_o(rd));
  vsf_status_flags uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr),
    .wr_data_i(wdat), .wr_i(wr), .rd_i(rd), .rd_data_o(rdat), .torque_at_limit_i(tq),
    .cmd_speed_i(cmd), .fb_speed_i(fb), .soft_limit_i(sl), .mech_limit_i(ml),
    .init_done_i(ini), .info_cond_i(inf), .forward_travel_sensor_i(pin[0]),
    .reverse_travel_sensor_i(pin[1]), .forward_motion_inhibit_i(pin[2]),
    .reverse_motion_inhibit_i(pin[3]), .drive_status_word_o(dsw),
    .velocity_attained_output_o(va), .halt_o(halt));
  function automatic int iabs(input int v); return (v < 0) ? -v : v; endfunction : iabs
  function automatic int rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return int'(seed);
  endfunction : rnd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test;
    if (failures == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    int r, s, h, md, rg, tg, f, c, e, t, tv;
    logic [31:0] d;
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    m.rd_reg(vsf_pkg::OFS_VA_RANGE, d);
    chk(d, 32'h0000_000A);
    m.rd_reg(8'h20, d);
    chk(d, 32'h0000_0000);
    for (int i = 0; i < 60; i++) begin
      r = rnd();
      s = rnd();
      h = r[0];
      md = r[1];
      rg = r[5:2];
      tg = $signed(s[4:0]);
      f = $signed(s[9:5]);
      c = (s[11:10] == 2'h0) ? 0 : $signed(s[15:12]);
      m.wr_reg(vsf_pkg::OFS_CONTROL, 32'(h << 8));
      m.wr_reg(vsf_pkg::OFS_TARGET, 32'(tg));
      m.wr_reg(vsf_pkg::OFS_VA_MODE, 32'(md));
      m.wr_reg(vsf_pkg::OFS_VA_RANGE, 32'(rg));
      m.wr_reg(vsf_pkg::OFS_STATUS, 32'hFFFF_FFFF);
      tq <= r[6];
      sl <= r[7] & r[8];
      ml <= r[9] & r[10];
      pin <= 4'(r[14:11] & {r[15], r[8], r[10], r[7]});
      ini <= s[0] ^ r[3];
      inf <= s[1] & r[2];
      fb <= 32'(f);
      cmd <= 32'(c);
      tv = md ? (iabs(f) + rg >= iabs(tg)) : (iabs(f - tg) <= rg);
      t = tv;
      if (h) t = (c == 0);
      e = (r[6] << 15) | ((c == 0) << 12) | (t << 10) | ((s[0] ^ r[3]) << 9);
      e |= (s[1] & r[2]) << 7;
      e |= ((r[7] & r[8]) | (r[9] & r[10]) | ((r[14:11] & {r[15], r[8], r[10], r[7]}) != 0)) << 11;
      repeat (5) @(posedge clk_sys_i);
      exp_q.push_back(e);
      chk({16'h0000, dsw}, 32'(e));
      chk(32'(va), 32'(tv));
      chk(32'(halt), 32'(h));
      m.rd_reg(vsf_pkg::OFS_STATUS, d);
      chk(d, 32'(exp_q.pop_front()));
    end
    // ==========================================================
    // Clock enable low freezes flags and ignores the port
    ce_i <= 1'b0;
    tq <= ~tq;
    m.wr_reg(vsf_pkg::OFS_CONTROL, 32'h0000_0000);
    repeat (4) @(posedge clk_sys_i);
    chk({16'h0000, dsw}, 32'(e));
    ce_i <= 1'b1;
    m.rd_reg(vsf_pkg::OFS_CONTROL, d);
    chk(d, 32'(h << 8));
    chk({16'h0000, dsw}, 32'(e) ^ 32'h0000_8000);
    // ==========================================================
    // Reset in mid-run clears flags and registers
    rst_n_i <= 1'b0;
    @(posedge clk_sys_i);
    chk({16'h0000, dsw}, 32'h0000_0000);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    m.rd_reg(vsf_pkg::OFS_CONTROL, d);
    chk(d, 32'h0000_0000);
    stop_test();
  end
endmodule : tb
`default_nettype wire
